// file: afdc_defines.svh
// Register map, field positions, reset values and timing counts of the fan loop
`ifndef AFDC_DEFINES_SVH
`define AFDC_DEFINES_SVH

// Register offsets
`define AFDC_ADDR_CFG 8'h00
`define AFDC_ADDR_FAN1_CHAR 8'h20
`define AFDC_ADDR_FAN2_CHAR 8'h21
`define AFDC_ADDR_MIN_DUTY 8'h22
`define AFDC_ADDR_LOCAL_THR 8'h24
`define AFDC_ADDR_REMOTE1_THR 8'h25
`define AFDC_ADDR_REMOTE2_THR 8'h26
`define AFDC_ADDR_DUTY_STAT 8'h2A

// Field positions
`define AFDC_CFG_AUTO_BIT 7
`define AFDC_CFG_SEL_HI 6
`define AFDC_CFG_SEL_LO 5
`define AFDC_SPIN_HI 2
`define AFDC_SPIN_LO 0
`define AFDC_TMIN_HI 7
`define AFDC_TMIN_LO 3
`define AFDC_SPAN_HI 2
`define AFDC_SPAN_LO 0
`define AFDC_DUTY_W 4

// Reset values
`define AFDC_RST_CFG 8'h80
`define AFDC_RST_FAN_CHAR 8'h1D
`define AFDC_RST_MIN_DUTY 8'h55
`define AFDC_RST_THR 8'h51

// Loop constants
`define AFDC_FULL_DUTY 4'hF
`define AFDC_HYST_DEG 10'sd5
`define AFDC_SPAN_MAX_CODE 3'h4
`define AFDC_CHANNELS 3
`define AFDC_FANS 2

// Spin-up interval as multiples of the base interval, per code
`define AFDC_SPIN_MULT_0 6'd1
`define AFDC_SPIN_MULT_1 6'd2
`define AFDC_SPIN_MULT_2 6'd3
`define AFDC_SPIN_MULT_3 6'd4
`define AFDC_SPIN_MULT_4 6'd5
`define AFDC_SPIN_MULT_5 6'd10
`define AFDC_SPIN_MULT_6 6'd20
`define AFDC_SPIN_MULT_7 6'd40

// Timing
`define AFDC_CLK_MHZ 100
`define AFDC_US_PER_MS 1000
`define AFDC_SPIN_BASE_MS 200
`define AFDC_SPIN_BASE_CYCLES (`AFDC_SPIN_BASE_MS * `AFDC_US_PER_MS * `AFDC_CLK_MHZ)
`define AFDC_PWM_PERIOD_US 32000
`define AFDC_PWM_SLOTS 8'd240
`define AFDC_SLOTS_PER_CODE 8'd16
`define AFDC_PWM_SLOT_CYCLES ((`AFDC_PWM_PERIOD_US * `AFDC_CLK_MHZ) / 240)

`endif

// file: afdc_pkg.sv
// Types shared by the fan loop modules
package afdc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic wr;
      logic rd;
   } afdc_reg_req_t;

   typedef struct packed {
      logic [7:0] localT;
      logic [7:0] remote1T;
      logic [7:0] remote2T;
   } afdc_temps_t;

   typedef enum logic [1:0] {
      SEL_SPLIT = 2'b00,
      SEL_REMOTE1 = 2'b01,
      SEL_REMOTE2 = 2'b10,
      SEL_FASTEST = 2'b11
   } afdc_sel_t;

   typedef enum logic [1:0] {
      FAN_OFF = 2'b00,
      FAN_SPIN = 2'b01,
      FAN_RUN = 2'b10
   } afdc_fan_state_t;

endpackage

// file: afdc_fan_drive.sv
// One fan output: spin-up sequencing and the 240-slot PWM generator
`timescale 1ns/1ns
`default_nettype none
`include "afdc_defines.svh"

module afdc_fan_drive
   import afdc_pkg::*;
#(
   parameter int unsigned SPIN_BASE_CYCLES = `AFDC_SPIN_BASE_CYCLES,
   parameter int unsigned PWM_SLOT_CYCLES = `AFDC_PWM_SLOT_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Loop demand
   input wire logic active,
   input wire logic [3:0] targetCode,
   input wire logic [2:0] spinCode,
   // Fan drive
   output logic pwmOut,
   output logic [3:0] dutyCode
);

   localparam int BW = $clog2(SPIN_BASE_CYCLES + 1);
   localparam int SW = $clog2(PWM_SLOT_CYCLES + 1);

   if (SPIN_BASE_CYCLES < 1 || PWM_SLOT_CYCLES < 1) begin : g_bad_param
      $error("afdc_fan_drive: cycle counts must be at least one");
   end

   afdc_fan_state_t state_r;
   logic [BW-1:0] baseCnt_r;
   logic [5:0] multCnt_r;
   logic [SW-1:0] slotCnt_r;
   logic [7:0] slotIdx_r;
   logic baseTick;
   logic spinDone;

   function automatic logic [5:0] spinMult(input logic [2:0] code);
      case (code)
         3'h0: spinMult = `AFDC_SPIN_MULT_0;
         3'h1: spinMult = `AFDC_SPIN_MULT_1;
         3'h2: spinMult = `AFDC_SPIN_MULT_2;
         3'h3: spinMult = `AFDC_SPIN_MULT_3;
         3'h4: spinMult = `AFDC_SPIN_MULT_4;
         3'h5: spinMult = `AFDC_SPIN_MULT_5;
         3'h6: spinMult = `AFDC_SPIN_MULT_6;
         default: spinMult = `AFDC_SPIN_MULT_7;
      endcase
   endfunction

   assign baseTick = (baseCnt_r == BW'(SPIN_BASE_CYCLES - 1));
   assign spinDone = baseTick && (multCnt_r == 6'h01);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= FAN_OFF;
      end else begin
         unique case (state_r)
            FAN_OFF: if (active) state_r <= FAN_SPIN;
            FAN_SPIN: begin
               if (!active) begin
                  state_r <= FAN_OFF;
               end else if (spinDone) begin
                  state_r <= FAN_RUN;
               end
            end
            FAN_RUN: if (!active) state_r <= FAN_OFF;
            default: state_r <= FAN_OFF;
         endcase
      end
   end

   // The interval code is reloaded while outside spin-up, so a rewrite mid spin-up waits
   always_ff @(posedge clk) begin
      if (rst || state_r != FAN_SPIN) begin
         baseCnt_r <= '0;
         multCnt_r <= spinMult(spinCode);
      end else if (baseTick) begin
         baseCnt_r <= '0;
         multCnt_r <= multCnt_r - 6'h01;
      end else begin
         baseCnt_r <= baseCnt_r + BW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dutyCode <= 4'h0;
      end else begin
         unique case (state_r)
            FAN_SPIN: dutyCode <= `AFDC_FULL_DUTY;
            FAN_RUN: dutyCode <= targetCode;
            default: dutyCode <= 4'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slotCnt_r <= '0;
         slotIdx_r <= 8'h00;
      end else if (slotCnt_r == SW'(PWM_SLOT_CYCLES - 1)) begin
         slotCnt_r <= '0;
         slotIdx_r <= (slotIdx_r == `AFDC_PWM_SLOTS - 8'h01) ? 8'h00 : slotIdx_r + 8'h01;
      end else begin
         slotCnt_r <= slotCnt_r + SW'(1);
      end
   end

   // Code 15 gives 240 high slots, so full duty never drops low
   always_ff @(posedge clk) begin
      if (rst) begin
         pwmOut <= 1'b0;
      end else begin
         pwmOut <= (slotIdx_r < 8'({4'h0, dutyCode} * `AFDC_SLOTS_PER_CODE));
      end
   end

endmodule
`default_nettype wire

// file: afdc_loop_top.sv
// Automatic fan duty loop: registers, three temperature loops and routing to two fans
`timescale 1ns/1ns
`default_nettype none
`include "afdc_defines.svh"

module afdc_loop_top
   import afdc_pkg::*;
#(
   parameter int unsigned SPIN_BASE_CYCLES = `AFDC_SPIN_BASE_CYCLES,
   parameter int unsigned PWM_SLOT_CYCLES = `AFDC_PWM_SLOT_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire afdc_reg_req_t regReq,
   output logic [7:0] regRdData,
   // Temperature readings, whole degrees, two's complement
   input wire afdc_temps_t temps,
   // Fan drive
   output logic [1:0] fanPwm
);

   if (SPIN_BASE_CYCLES < 1 || PWM_SLOT_CYCLES < 1) begin : g_bad_param
      $error("afdc_loop_top: cycle counts must be at least one");
   end

   logic [7:0] cfg_r;
   logic [7:0] fanChar_r [`AFDC_FANS];
   logic [7:0] minDuty_r;
   logic [7:0] thresh_r [`AFDC_CHANNELS];
   logic [`AFDC_CHANNELS-1:0] chanOn_r;
   logic [7:0] tempVec [`AFDC_CHANNELS];
   logic [3:0] chanSteps [`AFDC_CHANNELS];
   logic [3:0] fanDuty [`AFDC_FANS];
   logic autoMode;
   afdc_sel_t chanSel;

   assign tempVec[0] = temps.localT;
   assign tempVec[1] = temps.remote1T;
   assign tempVec[2] = temps.remote2T;
   assign autoMode = cfg_r[`AFDC_CFG_AUTO_BIT];
   assign chanSel = afdc_sel_t'(cfg_r[`AFDC_CFG_SEL_HI:`AFDC_CFG_SEL_LO]);

   // Duty of one loop for one fan: minimum at threshold, saturating at full
   function automatic logic [3:0] loopDuty(input logic on, input logic [3:0] minCode,
                                           input logic [3:0] steps);
      logic [4:0] sum;
      sum = {1'b0, minCode} + {1'b0, steps};
      if (!on) begin
         loopDuty = 4'h0;
      end else if (sum > {1'b0, `AFDC_FULL_DUTY}) begin
         loopDuty = `AFDC_FULL_DUTY;
      end else begin
         loopDuty = sum[3:0];
      end
   endfunction

   // Configuration registers; the power-up value already has automatic mode on
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r <= `AFDC_RST_CFG;
         fanChar_r[0] <= `AFDC_RST_FAN_CHAR;
         fanChar_r[1] <= `AFDC_RST_FAN_CHAR;
         minDuty_r <= `AFDC_RST_MIN_DUTY;
         thresh_r[0] <= `AFDC_RST_THR;
         thresh_r[1] <= `AFDC_RST_THR;
         thresh_r[2] <= `AFDC_RST_THR;
      end else if (regReq.wr) begin
         case (regReq.addr)
            `AFDC_ADDR_CFG: cfg_r <= regReq.wrData;
            `AFDC_ADDR_FAN1_CHAR: fanChar_r[0] <= regReq.wrData;
            `AFDC_ADDR_FAN2_CHAR: fanChar_r[1] <= regReq.wrData;
            `AFDC_ADDR_MIN_DUTY: minDuty_r <= regReq.wrData;
            `AFDC_ADDR_LOCAL_THR: thresh_r[0] <= regReq.wrData;
            `AFDC_ADDR_REMOTE1_THR: thresh_r[1] <= regReq.wrData;
            `AFDC_ADDR_REMOTE2_THR: thresh_r[2] <= regReq.wrData;
            default: ;
         endcase
      end
   end

   // Read data is registered: it appears the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regReq.rd) begin
         case (regReq.addr)
            `AFDC_ADDR_CFG: regRdData <= cfg_r;
            `AFDC_ADDR_FAN1_CHAR: regRdData <= fanChar_r[0];
            `AFDC_ADDR_FAN2_CHAR: regRdData <= fanChar_r[1];
            `AFDC_ADDR_MIN_DUTY: regRdData <= minDuty_r;
            `AFDC_ADDR_LOCAL_THR: regRdData <= thresh_r[0];
            `AFDC_ADDR_REMOTE1_THR: regRdData <= thresh_r[1];
            `AFDC_ADDR_REMOTE2_THR: regRdData <= thresh_r[2];
            `AFDC_ADDR_DUTY_STAT: regRdData <= {fanDuty[1], fanDuty[0]};
            default: regRdData <= 8'h00;
         endcase
      end
   end

   // One loop per temperature channel, each with its own threshold and span
   for (genvar c = 0; c < `AFDC_CHANNELS; c++) begin : g_chan
      logic signed [9:0] tMin;
      logic signed [9:0] tempDiff;
      logic [2:0] span;
      logic [8:0] halfSteps;

      always_comb begin
         tMin = $signed({3'b000, thresh_r[c][`AFDC_TMIN_HI:`AFDC_TMIN_LO], 2'b00});
         tempDiff = $signed({{2{tempVec[c][7]}}, tempVec[c]}) - tMin;
         // Codes above 80 degrees are not defined; they behave as the widest span
         if (thresh_r[c][`AFDC_SPAN_HI:`AFDC_SPAN_LO] > `AFDC_SPAN_MAX_CODE) begin
            span = `AFDC_SPAN_MAX_CODE;
         end else begin
            span = thresh_r[c][`AFDC_SPAN_HI:`AFDC_SPAN_LO];
         end
         // A tenth of the span is 2^span half-degrees, so count in half-degrees
         if (tempDiff > 10'sd0) begin
            halfSteps = {tempDiff[7:0], 1'b0} >> span;
         end else begin
            halfSteps = 9'h000;
         end
         chanSteps[c] = (halfSteps > 9'h00F) ? `AFDC_FULL_DUTY : halfSteps[3:0];
      end

      // Hysteresis: on strictly above threshold, off once 5 degrees below it
      always_ff @(posedge clk) begin
         if (rst) begin
            chanOn_r[c] <= 1'b0;
         end else if (tempDiff > 10'sd0) begin
            chanOn_r[c] <= 1'b1;
         end else if (tempDiff <= -`AFDC_HYST_DEG) begin
            chanOn_r[c] <= 1'b0;
         end
      end
   end

   // Per fan: evaluate every loop with this fan's minimum, then route
   for (genvar f = 0; f < `AFDC_FANS; f++) begin : g_fan
      logic [3:0] minCode;
      logic [3:0] duty [`AFDC_CHANNELS];
      logic [3:0] best;
      logic [3:0] target;
      logic active;
      logic [3:0] target_r;
      logic active_r;

      assign minCode = minDuty_r[f*`AFDC_DUTY_W +: `AFDC_DUTY_W];

      always_comb begin
         for (int c = 0; c < `AFDC_CHANNELS; c++) begin
            duty[c] = loopDuty(chanOn_r[c], minCode, chanSteps[c]);
         end
         // Fastest calculated duty wins, not the hottest channel
         best = duty[0];
         for (int c = 1; c < `AFDC_CHANNELS; c++) begin
            if (duty[c] > best) begin
               best = duty[c];
            end
         end
         unique case (chanSel)
            SEL_SPLIT: begin
               target = duty[f+1];
               active = chanOn_r[f+1];
            end
            SEL_REMOTE1: begin
               target = duty[1];
               active = chanOn_r[1];
            end
            SEL_REMOTE2: begin
               target = duty[2];
               active = chanOn_r[2];
            end
            SEL_FASTEST: begin
               target = best;
               active = |chanOn_r;
            end
         endcase
         // Software control drives the minimum nibble directly
         if (!autoMode) begin
            target = minCode;
            active = (minCode != 4'h0);
         end
      end

      // Registered so that routing changes reach the fan glitch-free
      always_ff @(posedge clk) begin
         if (rst) begin
            target_r <= 4'h0;
            active_r <= 1'b0;
         end else begin
            target_r <= target;
            active_r <= active;
         end
      end

      afdc_fan_drive #(
         .SPIN_BASE_CYCLES(SPIN_BASE_CYCLES),
         .PWM_SLOT_CYCLES(PWM_SLOT_CYCLES)
      ) u_drive (
         .clk(clk),
         .rst(rst),
         .active(active_r),
         .targetCode(target_r),
         .spinCode(fanChar_r[f][`AFDC_SPIN_HI:`AFDC_SPIN_LO]),
         .pwmOut(fanPwm[f]),
         .dutyCode(fanDuty[f])
      );
   end

endmodule
`default_nettype wire

// file: afdc_loop_checker.sv
// Port-level assertions for the fan loop top
`timescale 1ns/1ns
`default_nettype none
`include "afdc_defines.svh"

module afdc_loop_checker
   import afdc_pkg::*;
#(
   parameter int unsigned SPIN_BASE_CYCLES = `AFDC_SPIN_BASE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire afdc_reg_req_t regReq,
   input wire logic [7:0] regRdData,
   // Temperatures and fans
   input wire afdc_temps_t temps,
   input wire logic [1:0] fanPwm
);
   logic [7:0] shadow_r [7];
   logic [9:0] lowCnt_r [2];
   logic [31:0] runCnt_r [2];
   logic [1:0] started_r;
   logic [31:0] spinReq [2];
   localparam int unsigned SPIN_MULT [8] = '{1, 2, 3, 4, 5, 10, 20, 40};
   logic [7:0] expRd;
   logic autoOn;
   logic thrHot;

   function automatic int regIdx(logic [7:0] a);
      case (a)
         8'h00: return 0;
         8'h20: return 1;
         8'h21: return 2;
         8'h22: return 3;
         8'h24: return 4;
         8'h25: return 5;
         8'h26: return 6;
         default: return -1;
      endcase
   endfunction

   // Thresholds low and spans narrow enough that 127 C saturates the loop
   function automatic logic hotOk(logic [7:0] t);
      return t[7:3] <= 5'h19 && t[2:0] <= 3'h1;
   endfunction

   // High time that one start must at least show, per interval code
   function automatic int unsigned spinLen(logic [2:0] c);
      return SPIN_MULT[c] * SPIN_BASE_CYCLES;
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         shadow_r <= '{8'h80, 8'h1D, 8'h1D, 8'h55, 8'h51, 8'h51, 8'h51};
      end else if (regReq.wr && regIdx(regReq.addr) >= 0) begin
         shadow_r[regIdx(regReq.addr)] <= regReq.wrData;
      end
   end

   // A low run longer than one period means the fan is truly stopped
   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (rst || fanPwm[i]) lowCnt_r[i] <= 10'h000;
         else if (lowCnt_r[i] != 10'h3FF) lowCnt_r[i] <= lowCnt_r[i] + 10'h001;
         runCnt_r[i] <= (rst || !fanPwm[i]) ? 32'h0 : runCnt_r[i] + 32'h1;
         // Limitation: a loop idling at duty zero that rises again also looks like a start
         started_r[i] <= !rst && fanPwm[i] && (started_r[i] || lowCnt_r[i] >= 10'h1E1);
      end
   end

   always_comb begin
      expRd = (regIdx(regReq.addr) >= 0) ? shadow_r[regIdx(regReq.addr)] : 8'h00;
      autoOn = shadow_r[0][7];
      thrHot = hotOk(shadow_r[4]) && hotOk(shadow_r[5]) && hotOk(shadow_r[6]);
      spinReq[0] = spinLen(shadow_r[1][2:0]);
      spinReq[1] = spinLen(shadow_r[2][2:0]);
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence sSpinEnd(int i);
      $fell(fanPwm[i]) && started_r[i];
   endsequence
   sequence sSplit;
      (autoOn && shadow_r[0][6:5] == 2'b00 && hotOk(shadow_r[5]) && temps.remote1T == 8'h7F
         && temps.remote2T == 8'h80)[*8];
   endsequence
   property pRead;
      regReq.rd && regReq.addr != 8'h2A |=> regRdData == $past(expRd);
   endproperty
   sequence sHot;
      (autoOn && thrHot && temps == {3{8'h7F}})[*8];
   endsequence
   sequence sCold;
      (autoOn && temps == {3{8'h80}})[*8];
   endsequence

   a_reset_quiet: assert property ($fell(rst) |-> fanPwm == 2'b00 && regRdData == 8'h00)
      else $error("outputs not clear after reset");
   a_reg_readback: assert property (pRead)
      else $error("register read value wrong");
   a_read_holds: assert property (!regReq.rd |=> $stable(regRdData))
      else $error("read data moved without a read");
   a_cold_off: assert property (sCold |-> fanPwm == 2'b00)
      else $error("fan running while all channels cold");
   a_hot_full: assert property (sHot |-> fanPwm == 2'b11)
      else $error("fan not at full duty while hot");
   a_split_route: assert property (sSplit |-> fanPwm == 2'b01)
      else $error("split routing wrong");
   a_sw_idle: assert property ((!autoOn && shadow_r[3][3:0] == 4'h0)[*8] |-> !fanPwm[0])
      else $error("fan 1 running in software mode at zero duty");
   a_spin1_full: assert property (sSpinEnd(0) |-> runCnt_r[0] >= spinReq[0])
      else $error("fan 1 start without full spin-up");
   a_spin2_full: assert property (sSpinEnd(1) |-> runCnt_r[1] >= spinReq[1])
      else $error("fan 2 start without full spin-up");
endmodule

bind afdc_loop_top afdc_loop_checker #(.SPIN_BASE_CYCLES(SPIN_BASE_CYCLES)) chk_u (.clk(clk),
   .rst(rst), .regReq(regReq),
   .regRdData(regRdData), .temps(temps), .fanPwm(fanPwm));

`default_nettype wire

// file: afdc_fan_model.sv
// Fan model: senses the high time of its drive over each full period
`timescale 1ns/1ns
`default_nettype none

module afdc_fan_model #(
   parameter int unsigned PERIOD = 480
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Drive from the controller
   input wire logic pwm,
   output logic [9:0] winHigh
);
   logic [9:0] cnt_r;
   logic [9:0] acc_r;

   // Any window of one period length sees the full duty when it is steady
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 10'h000;
         acc_r <= 10'h000;
         winHigh <= 10'h000;
      end else if (cnt_r == 10'(PERIOD - 1)) begin
         winHigh <= acc_r + 10'(pwm);
         acc_r <= 10'h000;
         cnt_r <= 10'h000;
      end else begin
         acc_r <= acc_r + 10'(pwm);
         cnt_r <= cnt_r + 10'h001;
      end
   end
endmodule

`default_nettype wire

// file: afdc_loop_top_test.sv
// Self-checking bench of the automatic fan duty loop
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; \
   if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module afdc_loop_top_test
   import afdc_pkg::*;
;
   localparam int SPIN = 10;
   localparam int SLOT = 2;
   localparam int PERIOD = 240 * SLOT;
   localparam int MULT [8] = '{1, 2, 3, 4, 5, 10, 20, 40};
   localparam logic [7:0] ADDRS [9] = '{8'h00, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26,
      8'h2A, 8'h30};
   localparam logic [7:0] RSTV [9] = '{8'h80, 8'h1D, 8'h1D, 8'h55, 8'h51, 8'h51, 8'h51,
      8'h00, 8'h00};
   logic clk = 1'b0;
   logic rst = 1'b1;
   afdc_reg_req_t regReq = '0;
   afdc_temps_t temps = {3{8'h80}};
   logic [7:0] regRdData;
   logic [1:0] fanPwm;
   logic [9:0] winHigh [2];
   int miscompares = 0;
   int totalChecks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'hC67C;

   always #5 clk = ~clk;

   afdc_loop_top #(.SPIN_BASE_CYCLES(SPIN), .PWM_SLOT_CYCLES(SLOT)) dut_u (.clk(clk), .rst(rst),
      .regReq(regReq), .regRdData(regRdData), .temps(temps), .fanPwm(fanPwm));

   for (genvar i = 0; i < 2; i++) begin : g_fan
      afdc_fan_model #(.PERIOD(PERIOD)) fan_u (.clk(clk), .rst(rst), .pwm(fanPwm[i]),
         .winHigh(winHigh[i]));
   end

   function automatic logic [31:0] nextRand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Returns {on, duty code} of one channel loop
   function automatic logic [4:0] chDuty(logic [7:0] thr, logic [3:0] mn, logic [7:0] t);
      int dt;
      int d;
      dt = $signed(t) - int'(thr[7:3]) * 4;
      if (dt <= 0) return 5'h00;
      d = mn + ((2 * dt) >> (thr[2:0] > 3'h4 ? 3'h4 : thr[2:0]));
      return {1'b1, d > 15 ? 4'hF : 4'(d)};
   endfunction

   task automatic wrReg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      regReq.addr <= a;
      regReq.wrData <= d;
      regReq.wr <= 1'b1;
      @(posedge clk);
      regReq.wr <= 1'b0;
   endtask

   task automatic rdReg(logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regReq.addr <= a;
      regReq.rd <= 1'b1;
      @(posedge clk);
      regReq.rd <= 1'b0;
      #1;
      d = regRdData;
   endtask

   task automatic hold1(logic [7:0] t, int n, output logic [7:0] v);
      @(posedge clk);
      temps.remote1T <= t;
      repeat (n) @(posedge clk);
      rdReg(8'h2A, v);
   endtask

   task automatic runRound(logic [23:0] thr, logic [7:0] mins, logic [1:0] sel,
      logic [23:0] t, bit pwm);
      logic [4:0] l, r1, r2, mx;
      logic [3:0] mn;
      logic [7:0] v;
      logic [7:0] e;
      @(posedge clk);
      temps <= {3{8'h80}};
      wrReg(8'h24, thr[23:16]);
      wrReg(8'h25, thr[15:8]);
      wrReg(8'h26, thr[7:0]);
      wrReg(8'h22, mins);
      wrReg(8'h00, {1'b1, sel, 5'h00});
      repeat (12) @(posedge clk);
      temps <= t;
      repeat (60) @(posedge clk);
      rdReg(8'h2A, v);
      for (int f = 0; f < 2; f++) begin
         mn = f ? mins[7:4] : mins[3:0];
         l = chDuty(thr[23:16], mn, t[23:16]);
         r1 = chDuty(thr[15:8], mn, t[15:8]);
         r2 = chDuty(thr[7:0], mn, t[7:0]);
         mx = (l > r1) ? l : r1;
         mx = (mx > r2) ? mx : r2;
         if (sel == 2'b00) mx = f ? r2 : r1;
         else if (sel == 2'b01) mx = r1;
         else if (sel == 2'b10) mx = r2;
         e[f*4 +: 4] = mx[3:0];
      end
      `CHK("duty status", e, v)
      if (pwm) begin
         repeat (2 * PERIOD + 20) @(posedge clk);
         `CHK("fan 1 high time", {1'b0, e[3:0], 5'h00}, winHigh[0])
         `CHK("fan 2 high time", {1'b0, e[7:4], 5'h00}, winHigh[1])
      end
   endtask

   task final_report();
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         final_report();
      end
   end

   initial begin
      logic [7:0] v;
      logic [31:0] r;
      logic [23:0] thr, tt;
      int n, k;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wrReg(8'h2A, 8'hFF);
      wrReg(8'h30, 8'hFF);
      for (int i = 0; i < 9; i++) begin
         rdReg(ADDRS[i], v);
         `CHK("reset value", RSTV[i], v)
      end
      @(posedge clk);
      temps <= {3{8'h7F}};
      repeat (150) @(posedge clk);
      rdReg(8'h2A, v);
      `CHK("hot duty", 8'hFF, v)
      wrReg(8'h20, 8'h18);
      wrReg(8'h21, 8'h18);
      runRound(24'h515151, 8'h55, 2'b00, 24'h007F80, 1'b1);
      runRound(24'h510351, 8'h88, 2'b01, 24'h801B80, 1'b1);
      hold1(8'hFC, 10, v);
      `CHK("warm hold", 1'b1, v[3:0] != 4'h0)
      hold1(8'hFB, 10, v);
      `CHK("cooled off", 8'h00, v)
      hold1(8'h00, 10, v);
      `CHK("at threshold", 8'h00, v)
      hold1(8'h01, 40, v);
      `CHK("just above", 8'h88, v)
      runRound(24'h510351, 8'h88, 2'b01, 24'h801C80, 1'b0);
      runRound(24'h2C0051, 8'h55, 2'b11, 24'h3C0A80, 1'b1);
      // Span code 111 behaves as the widest span; remote 2 drives both fans
      runRound(24'h515107, 8'h55, 2'b10, 24'h808028, 1'b0);
      repeat (12) begin
         r = nextRand();
         for (int j = 0; j < 3; j++) thr[j*8 +: 8] = {1'b0, r[4*j +: 4], 3'(r[12+3*j +: 3] % 5)};
         r = nextRand();
         for (int j = 0; j < 3; j++) tt[j*8 +: 8] = 8'(int'(r[j*8 +: 6]) - 8);
         r = nextRand();
         runRound(thr, r[7:0] | 8'h11, r[9:8], tt, 1'b0);
      end
      // Zero running duty makes the high run equal the spin-up interval
      wrReg(8'h25, 8'h14);
      wrReg(8'h22, 8'h50);
      wrReg(8'h00, 8'h80);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         temps <= {3{8'h80}};
         wrReg(8'h20, {5'h03, 3'(c)});
         repeat (500) @(posedge clk);
         temps.remote1T <= 8'h09;
         n = 0;
         k = 0;
         while (fanPwm[0] !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
         end
         while (fanPwm[0] === 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
         end
         k = MULT[c] * SPIN;
         `CHK("spin length", 1'b1, n >= k - 1 && n <= k + 2)
      end
      wrReg(8'h22, 8'hA0);
      wrReg(8'h00, 8'h00);
      repeat (40) @(posedge clk);
      rdReg(8'h2A, v);
      `CHK("software duty", 8'hA0, v)
      repeat (2 * PERIOD + 20) @(posedge clk);
      `CHK("software fan 2", 10'h140, winHigh[1])
      `CHK("software fan 1", 10'h000, winHigh[0])
      final_report();
   end
endmodule

`default_nettype wire
